/* File: inc/dacw_pkg.sv */
// constants, types and timing for the dac i2c write and command decoder
//
// Summary of operation
// - address, pointer, two data bytes, then stop
// - pointer picks channel; top bit zero on 8ch
// - no stop: new pointer plus data updates again
// - register select bits choose the channel register
// - stop ends any framing, back to idle
// - pointer 0xff starts burst at channel zero
// - burst increments; after last channel, pointer framing
// - toggle writes ignored during burst
// - select zero: channel bits decode commands
// - no-op changes nothing, busy low meanwhile
// - clear-code write stores word; resets to zero
// - clear pin or soft clear loads clear code
// - soft clear busy 20us wide, 15us narrow
// - soft power-down global; registers kept
// - power-up ends power-down 8us later
// - power-down is hardware OR software
// - soft reset defaults all, zeros dacs, 135us
// - monitor code from bits 13:8 or 11:6
// - codes 0-15 channels (0-7 on 8ch), 36/37 external inputs
// - monitor code 63 floats monitor output
// - slave address 10101 plus select pins, writes only
// - ack by pulling sda low on ninth clock
`default_nettype none

package dacw_pkg;
	// ******************************************
	// link framing
	// ******************************************
	localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h15;
	localparam logic [7:0] PTR_BURST = 8'hff;
	localparam int PTR_READ_BIT = 4;
	localparam logic [3:0] BIT_COUNT_ACK = 4'h8;
	localparam logic [3:0] CHAN_LAST_WIDE = 4'hf;
	localparam logic [3:0] CHAN_LAST_NARROW = 4'h7;
	localparam logic [1:0] REG_SEL_COMMAND = 2'h0;
	localparam logic [1:0] REG_SEL_DATA = 2'h3;
	localparam int DATA_WIDTH = 14;
	localparam int UPD_WIDTH = 4 + 2 + DATA_WIDTH;

	// ******************************************
	// special function commands
	// ******************************************
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_CLEAR_CODE = 4'h1;
	localparam logic [3:0] CMD_SOFT_CLEAR = 4'h2;
	localparam logic [3:0] CMD_POWER_DOWN = 4'h8;
	localparam logic [3:0] CMD_POWER_UP = 4'h9;
	localparam logic [3:0] CMD_MONITOR = 4'ha;
	localparam logic [3:0] CMD_CONTROL = 4'hc;
	localparam logic [3:0] CMD_SOFT_RESET = 4'hf;

	// ******************************************
	// monitor codes and reset values
	// ******************************************
	localparam logic [5:0] MON_EXT_ONE = 6'h24;
	localparam logic [5:0] MON_EXT_TWO = 6'h25;
	localparam logic [5:0] MON_HIZ = 6'h3f;
	localparam logic [5:0] MON_RESET = 6'h3f;
	localparam logic [DATA_WIDTH-1:0] CLEAR_CODE_RESET = 14'h0000;
	localparam logic [DATA_WIDTH-1:0] CONTROL_RESET = 14'h3000;

	// ******************************************
	// timing
	// ******************************************
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int CYC_PER_US = SYS_CLK_HZ / 1_000_000;
	localparam int SOFT_CLR_US_WIDE = 20;
	localparam int SOFT_CLR_US_NARROW = 15;
	localparam int POWER_UP_US = 8;
	localparam int SOFT_RESET_US = 135;
	localparam int SOFT_CLR_CYC_WIDE = SOFT_CLR_US_WIDE * CYC_PER_US;
	localparam int SOFT_CLR_CYC_NARROW = SOFT_CLR_US_NARROW * CYC_PER_US;
	localparam int POWER_UP_CYC = POWER_UP_US * CYC_PER_US;
	localparam int SOFT_RESET_CYC = SOFT_RESET_US * CYC_PER_US;
	localparam int BUSY_CNT_WIDTH = 13;

	// receiver states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_PTR = 3'b010,
		ST_DATA_HI = 3'b011,
		ST_DATA_LO = 3'b100
	} dacw_state_type;
endpackage : dacw_pkg

`default_nettype wire

/* File: src/dacw_decoder.sv */
// i2c write receiver and special function command decoder for the dac
`default_nettype none

module dacw_decoder #(
	parameter int SOFT_RESET_CYCLES = dacw_pkg::SOFT_RESET_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic slave_address_select_high,
	input wire logic slave_address_select_low,
	input wire logic variant_narrow,
	input wire logic variant_12bit,
	input wire logic toggle_mode,
	input wire logic clear_input_n,
	input wire logic hw_power_down,
	output logic upd_valid,
	input wire logic upd_ready,
	output logic [3:0] upd_channel,
	output logic [1:0] upd_reg_sel,
	output logic [dacw_pkg::DATA_WIDTH-1:0] upd_data,
	output logic dac_clear_strobe,
	output logic dac_reset_strobe,
	output logic [dacw_pkg::DATA_WIDTH-1:0] clear_code,
	output logic [dacw_pkg::DATA_WIDTH-1:0] control_word,
	output logic control_read_strobe,
	output logic busy_n,
	output logic sw_power_down,
	output logic power_down,
	output logic [5:0] monitor_code,
	output logic monitor_channel_sel,
	output logic monitor_ext_one_sel,
	output logic monitor_ext_two_sel,
	output logic monitor_hiz,
	output logic burst_active
);
	import dacw_pkg::*;

	// highest channel for the fitted variant
	function automatic logic [3:0] last_channel(input logic narrow);
		last_channel = narrow ? CHAN_LAST_NARROW : CHAN_LAST_WIDE;
	endfunction : last_channel

	// ******************************************
	// pin synchronisers
	// ******************************************
	logic scl_s1_q, scl_s2_q, scl_s3_q;
	logic sda_s1_q, sda_s2_q, sda_s3_q;
	logic clr_s1_q, clr_s2_q, clr_s3_q;
	logic hwpd_s1_q, hwpd_s2_q;

	// two flops per pin, third flop only for edge finding
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
			clr_s1_q <= 1'b1;
			clr_s2_q <= 1'b1;
			clr_s3_q <= 1'b1;
			hwpd_s1_q <= 1'b0;
			hwpd_s2_q <= 1'b0;
		end else if (clk_en) begin
			scl_s1_q <= scl_in;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= sda_in;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
			clr_s1_q <= clear_input_n;
			clr_s2_q <= clr_s1_q;
			clr_s3_q <= clr_s2_q;
			hwpd_s1_q <= hw_power_down;
			hwpd_s2_q <= hwpd_s1_q;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise = scl_s2_q & ~scl_s3_q;
	assign scl_fall = ~scl_s2_q & scl_s3_q;
	// sda moving while scl is high marks start and stop
	assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	assign stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

	// ******************************************
	// byte receiver
	// ******************************************
	dacw_state_type state_q, state_d;
	logic [7:0] shift_q, data_hi_q;
	logic [3:0] bit_cnt_q, chan_q, cmd_ptr_q;
	logic in_ack_q, sda_oe_q, burst_q, read_q;
	logic byte_done, ack_ok, word_done;
	logic [1:0] word_sel;
	logic [DATA_WIDTH-1:0] word_data;
	logic push_valid, push_ready;
	logic toggle_drop, cmd_fire;

	assign byte_done = scl_fall & (bit_cnt_q == BIT_COUNT_ACK) & ~in_ack_q;
	// high byte first, select bits on top of it
	assign word_sel = data_hi_q[7:6];
	assign word_data = {data_hi_q[5:0], shift_q};
	// toggle writes go nowhere while the pointer auto-increments
	assign toggle_drop = burst_q & toggle_mode & (word_sel == REG_SEL_DATA);

	// decide acknowledge and next framing step per received byte
	always_comb begin
		ack_ok = 1'b0;
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: state_d = ST_IDLE;
			ST_ADDR: begin
				// fixed upper bits, pin-selected lower bits, writes only
				ack_ok = (shift_q[7:1] == {SLAVE_ADDR_FIXED, slave_address_select_high,
					slave_address_select_low}) & ~shift_q[0];
				state_d = ST_PTR;
			end
			ST_PTR: begin
				ack_ok = 1'b1;
				state_d = ST_DATA_HI;
			end
			ST_DATA_HI: begin
				ack_ok = 1'b1;
				state_d = ST_DATA_LO;
			end
			ST_DATA_LO: begin
				// a full buffer refuses the word by withholding the ack
				ack_ok = (word_sel == REG_SEL_COMMAND) | toggle_drop | push_ready;
				if (burst_q && chan_q != last_channel(variant_narrow)) begin
					state_d = ST_DATA_HI;
				end else begin
					state_d = ST_PTR;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	assign word_done = byte_done & (state_q == ST_DATA_LO) & ack_ok;
	assign cmd_fire = word_done & (word_sel == REG_SEL_COMMAND);
	assign push_valid = word_done & (word_sel != REG_SEL_COMMAND) & ~toggle_drop;

	// bit counting, ack driving and framing
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			in_ack_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (clk_en) begin
			if (start_det) begin
				state_q <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				in_ack_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end else if (stop_det) begin
				// stop drops every framing at once
				state_q <= ST_IDLE;
				bit_cnt_q <= 4'h0;
				in_ack_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end else if (state_q != ST_IDLE) begin
				if (scl_rise && !in_ack_q && bit_cnt_q != BIT_COUNT_ACK) begin
					shift_q <= {shift_q[6:0], sda_s2_q};
					bit_cnt_q <= bit_cnt_q + 4'h1;
				end else if (byte_done) begin
					// hold sda low through the ninth clock
					in_ack_q <= 1'b1;
					sda_oe_q <= ack_ok;
					state_q <= ack_ok ? state_d : ST_IDLE;
				end else if (scl_fall && in_ack_q) begin
					in_ack_q <= 1'b0;
					sda_oe_q <= 1'b0;
					bit_cnt_q <= 4'h0;
				end
			end
		end
	end

	// pointer, burst and held high byte
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			burst_q <= 1'b0;
			read_q <= 1'b0;
			chan_q <= 4'h0;
			cmd_ptr_q <= 4'h0;
			data_hi_q <= 8'h00;
		end else if (clk_en) begin
			if (start_det || stop_det) begin
				burst_q <= 1'b0;
			end else if (byte_done && state_q == ST_PTR) begin
				read_q <= shift_q[PTR_READ_BIT];
				cmd_ptr_q <= shift_q[3:0]; // full code on either variant
				if (shift_q == PTR_BURST) begin
					burst_q <= 1'b1;
					chan_q <= 4'h0;
					read_q <= 1'b0;
				end else begin
					burst_q <= 1'b0;
					// the narrow part has no top address bit
					chan_q <= {shift_q[3] & ~variant_narrow, shift_q[2:0]};
				end
			end else if (byte_done && state_q == ST_DATA_HI) begin
				data_hi_q <= shift_q;
			end else if (word_done && burst_q) begin
				if (chan_q == last_channel(variant_narrow)) begin
					burst_q <= 1'b0;
				end else begin
					chan_q <= chan_q + 4'h1;
				end
			end
		end
	end

	assign sda_oe = sda_oe_q;
	assign sda_out = 1'b0;
	assign burst_active = burst_q;

	// ******************************************
	// two-entry channel write buffer
	// ******************************************
	logic [UPD_WIDTH-1:0] fifo_mem_q [2];
	logic fifo_wr_q, fifo_rd_q;
	logic [1:0] fifo_cnt_q;
	logic fifo_pop;

	assign push_ready = (fifo_cnt_q != 2'h2);
	assign upd_valid = (fifo_cnt_q != 2'h0);
	assign fifo_pop = upd_valid & upd_ready;

	// a stalled sink fills it and then the link sees a nack
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_mem_q[0] <= '0;
			fifo_mem_q[1] <= '0;
			fifo_wr_q <= 1'b0;
			fifo_rd_q <= 1'b0;
			fifo_cnt_q <= 2'h0;
		end else if (clk_en) begin
			if (push_valid) begin
				fifo_mem_q[fifo_wr_q] <= {chan_q, word_sel, word_data};
				fifo_wr_q <= ~fifo_wr_q;
			end
			if (fifo_pop) begin
				fifo_rd_q <= ~fifo_rd_q;
			end
			fifo_cnt_q <= fifo_cnt_q + {1'b0, push_valid} - {1'b0, fifo_pop};
		end
	end

	assign upd_channel = fifo_mem_q[fifo_rd_q][UPD_WIDTH-1 -: 4];
	assign upd_reg_sel = fifo_mem_q[fifo_rd_q][DATA_WIDTH +: 2];
	assign upd_data = fifo_mem_q[fifo_rd_q][DATA_WIDTH-1:0];

	// ******************************************
	// special function commands
	// ******************************************
	logic [DATA_WIDTH-1:0] clear_code_q, control_q;
	logic [5:0] mon_code_q;
	logic sw_pd_q, hw_clear;
	logic clear_q, reset_q, ctrl_rd_q, nop_q;
	logic [BUSY_CNT_WIDTH-1:0] busy_cnt_q, settle_cnt_q;
	logic [5:0] mon_new;
	logic [3:0] cmd;

	// the narrow part drops the top channel bit, but command codes need it
	assign cmd = burst_q ? chan_q : cmd_ptr_q;
	// monitor code sits lower on the 12-bit part
	assign mon_new = variant_12bit ? word_data[11:6] : word_data[13:8];
	// clear pin acts on its falling edge after sync
	assign hw_clear = clr_s3_q & ~clr_s2_q;

	// stored command state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clear_code_q <= CLEAR_CODE_RESET;
			control_q <= CONTROL_RESET;
			mon_code_q <= MON_RESET;
			sw_pd_q <= 1'b0;
		end else if (clk_en && cmd_fire) begin
			unique case (cmd)
				CMD_CLEAR_CODE: clear_code_q <= word_data;
				CMD_POWER_DOWN: sw_pd_q <= 1'b1;
				CMD_POWER_UP: sw_pd_q <= 1'b0;
				CMD_MONITOR: mon_code_q <= mon_new;
				CMD_CONTROL: if (!read_q) control_q <= word_data;
				CMD_SOFT_RESET: begin
					// registers back to defaults; dac values zeroed outside
					clear_code_q <= CLEAR_CODE_RESET;
					control_q <= CONTROL_RESET;
					mon_code_q <= MON_RESET;
					sw_pd_q <= 1'b0;
				end
				default: clear_code_q <= clear_code_q; // no-op and unassigned codes: no change
			endcase
		end
	end

	// one-cycle strobes toward the channel registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clear_q <= 1'b0;
			reset_q <= 1'b0;
			ctrl_rd_q <= 1'b0;
			nop_q <= 1'b0;
		end else if (clk_en) begin
			clear_q <= hw_clear | (cmd_fire & (cmd == CMD_SOFT_CLEAR));
			reset_q <= cmd_fire & (cmd == CMD_SOFT_RESET);
			ctrl_rd_q <= cmd_fire & (cmd == CMD_CONTROL) & read_q;
			nop_q <= cmd_fire & (cmd == CMD_NOP);
		end
	end

	// busy time of soft clear and soft reset; also power-up settling
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_cnt_q <= '0;
			settle_cnt_q <= '0;
		end else if (clk_en) begin
			if (cmd_fire && cmd == CMD_SOFT_CLEAR) begin
				busy_cnt_q <= variant_narrow ? BUSY_CNT_WIDTH'(SOFT_CLR_CYC_NARROW) :
					BUSY_CNT_WIDTH'(SOFT_CLR_CYC_WIDE);
			end else if (cmd_fire && cmd == CMD_SOFT_RESET) begin
				busy_cnt_q <= BUSY_CNT_WIDTH'(SOFT_RESET_CYCLES);
			end else if (busy_cnt_q != '0) begin
				busy_cnt_q <= busy_cnt_q - 1'b1;
			end
			if (cmd_fire && cmd == CMD_POWER_UP) begin
				settle_cnt_q <= BUSY_CNT_WIDTH'(POWER_UP_CYC);
			end else if (cmd_fire && cmd == CMD_POWER_DOWN) begin
				settle_cnt_q <= '0;
			end else if (settle_cnt_q != '0) begin
				settle_cnt_q <= settle_cnt_q - 1'b1;
			end
		end
	end

	assign busy_n = (busy_cnt_q == '0) & ~nop_q;
	// settling counts as still powered down
	assign power_down = hwpd_s2_q | sw_pd_q | (settle_cnt_q != '0);
	assign sw_power_down = sw_pd_q;
	assign clear_code = clear_code_q;
	assign control_word = control_q;
	assign control_read_strobe = ctrl_rd_q;
	assign dac_clear_strobe = clear_q;
	assign dac_reset_strobe = reset_q;

	// ******************************************
	// monitor routing decode
	// ******************************************
	assign monitor_code = mon_code_q;
	assign monitor_channel_sel = (mon_code_q[5:4] == 2'h0) &
		(mon_code_q[3:0] <= last_channel(variant_narrow));
	assign monitor_ext_one_sel = (mon_code_q == MON_EXT_ONE);
	assign monitor_ext_two_sel = (mon_code_q == MON_EXT_TWO);
	// other codes select nothing in particular
	assign monitor_hiz = (mon_code_q == MON_HIZ);
endmodule : dacw_decoder

`default_nettype wire

/* File: test/dacw_asserts.sv */
// concurrent checks on the dac write decoder ports
`default_nettype none

module dacw_checker #(
	parameter int SOFT_RESET_CYCLES = 20
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic upd_valid,
	input wire logic upd_ready,
	input wire logic [dacw_pkg::DATA_WIDTH-1:0] upd_data,
	input wire logic dac_clear_strobe,
	input wire logic dac_reset_strobe,
	input wire logic busy_n,
	input wire logic sw_power_down,
	input wire logic power_down,
	input wire logic [5:0] monitor_code,
	input wire logic monitor_ext_one_sel,
	input wire logic monitor_hiz
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ****
	// sequences and properties
	// ****
	sequence s_busy_held; !busy_n [*8]; endsequence
	sequence s_pd_held; power_down [*8]; endsequence
	property p_sda_low; sda_oe |-> !sda_out; endproperty
	property p_upd_hold; upd_valid && !upd_ready |=> upd_valid && $stable(upd_data); endproperty
	property p_clr_pulse; dac_clear_strobe |=> !dac_clear_strobe; endproperty
	property p_clr_busy; dac_clear_strobe && !busy_n |=> s_busy_held; endproperty
	property p_rst_busy; dac_reset_strobe |=> s_busy_held; endproperty
	property p_pd_or; sw_power_down |-> power_down; endproperty
	property p_pd_up; $fell(sw_power_down) |-> s_pd_held; endproperty
	property p_hiz; monitor_hiz == (monitor_code == 6'h3f); endproperty
	property p_ext; monitor_ext_one_sel == (monitor_code == 6'h24); endproperty
	a_sda_low: assert property (p_sda_low) else $error("ack drives high");
	a_upd_hold: assert property (p_upd_hold) else $error("head word lost");
	a_clr_pulse: assert property (p_clr_pulse) else $error("clear strobe long");
	a_clr_busy: assert property (p_clr_busy) else $error("clear busy short");
	a_rst_busy: assert property (p_rst_busy) else $error("reset busy short");
	a_pd_or: assert property (p_pd_or) else $error("power down not or");
	a_pd_up: assert property (p_pd_up) else $error("power up early");
	a_hiz: assert property (p_hiz) else $error("hiz decode");
	a_ext: assert property (p_ext) else $error("ext one decode");
endmodule : dacw_checker

bind dacw_decoder dacw_checker #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) chk (.sys_clk(sys_clk),
	.rst_n(rst_n), .sda_out(sda_out), .sda_oe(sda_oe), .upd_valid(upd_valid), .upd_ready(upd_ready),
	.upd_data(upd_data), .dac_clear_strobe(dac_clear_strobe), .dac_reset_strobe(dac_reset_strobe),
	.busy_n(busy_n), .sw_power_down(sw_power_down), .power_down(power_down),
	.monitor_code(monitor_code), .monitor_ext_one_sel(monitor_ext_one_sel), .monitor_hiz(monitor_hiz));

`default_nettype wire

/* File: test/dacw_master.sv */
// i2c master model that writes to the dac receiver
`default_nettype none

module dacw_master (
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// bus idle: scl stands high, sda left to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// start: sda falls with scl high
	task automatic start();
		#50 sda_low = 1'b1;
		#50 scl = 1'b0;
	endtask : start
	// stop: sda rises with scl high, then the clock stands still
	task automatic stop();
		#50 sda_low = 1'b1;
		#50 scl = 1'b1;
		#50 sda_low = 1'b0;
		#100;
	endtask : stop
	// data changes only mid low phase so no false start or stop
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#50 sda_low = !b[i];
			#50 scl = 1'b1;
			#100 scl = 1'b0;
		end
		#50 sda_low = 1'b0;
		#50 scl = 1'b1;
		#50 ack = !sda;
		#50 scl = 1'b0;
	endtask : wbyte
endmodule : dacw_master

`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the dac write decoder
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dacw_pkg::*;
	logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, ad_hi, ad_lo, narrow = 1'b1, w12 = 1'b0;
	logic tgl = 1'b0, clr_n = 1'b1, hw_pd = 1'b0, rdy = 1'b0, scl, m_low, sda_oe, sda_out, ack;
	logic upd_valid, clr_s, rst_s, rd_s, busy_n, sw_pd, pd, burst, ext1, ext2, chsel, hiz;
	logic [3:0] ch;
	logic [1:0] rs;
	logic [13:0] ud, ccode, cword;
	logic [5:0] mcode;
	logic [19:0] got[$];
	int error_cnt = 0, total_checks = 0, seed = 32'h351e, cyc = 0, n_clr, n_rst, n_rd, n_busy, n_pd;
	wire sda = !(m_low || (sda_oe && !sda_out));

	dacw_decoder #(.SOFT_RESET_CYCLES(20)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .slave_address_select_high(ad_hi),
		.slave_address_select_low(ad_lo), .variant_narrow(narrow), .variant_12bit(w12), .toggle_mode(tgl),
		.clear_input_n(clr_n), .hw_power_down(hw_pd), .upd_valid(upd_valid), .upd_ready(rdy),
		.upd_channel(ch), .upd_reg_sel(rs), .upd_data(ud), .dac_clear_strobe(clr_s),
		.dac_reset_strobe(rst_s), .clear_code(ccode), .control_word(cword), .control_read_strobe(rd_s),
		.busy_n(busy_n), .sw_power_down(sw_pd), .power_down(pd), .monitor_code(mcode),
		.monitor_channel_sel(chsel), .monitor_ext_one_sel(ext1), .monitor_ext_two_sel(ext2),
		.monitor_hiz(hiz), .burst_active(burst));
	dacw_master m (.scl(scl), .sda_low(m_low), .sda(sda));

	// ****
	// clock, counters, timeout
	// ****
	always #12.5 sys_clk = !sys_clk;
	// tallies pulses and busy cycles; pops go to a queue for ordering checks
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 30000) begin
			error_cnt++;
			test_done();
		end
		n_clr += (clr_s === 1'b1);
		n_rst += (rst_s === 1'b1);
		n_rd += (rd_s === 1'b1);
		n_busy += (busy_n === 1'b0);
		n_pd += (pd === 1'b1 && sw_pd === 1'b0);
		if (upd_valid === 1'b1 && rdy === 1'b1) got.push_back({ch, rs, ud});
	end

	// ****
	// helpers
	// ****
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	function automatic logic [7:0] adr(input logic rw);
		return {SLAVE_ADDR_FIXED, ad_hi, ad_lo, rw};
	endfunction : adr
	// expected select outputs: channel, ext one, ext two, hiz
	function automatic logic [3:0] mon_exp(input logic [5:0] c, input logic nw);
		return {c <= (nw ? 6'd7 : 6'd15), c == MON_EXT_ONE, c == MON_EXT_TWO, c == MON_HIZ};
	endfunction : mon_exp
	task automatic send(input logic [7:0] b);
		m.wbyte(b, ack);
	endtask : send
	task automatic upd(input logic [7:0] p, input logic [1:0] r, input logic [13:0] d);
		send(p);
		send({r, d[13:8]});
		send(d[7:0]);
	endtask : upd
	task automatic frame(input logic [7:0] p, input logic [1:0] r, input logic [13:0] d);
		m.start();
		send(adr(1'b0));
		upd(p, r, d);
		m.stop();
		tick(4);
	endtask : frame
	// bounded wait for a popped word; none arriving reads as unknown
	task automatic expect_word(input logic [19:0] e);
		logic [19:0] w;
		for (int k = 0; k < 200 && got.size() == 0; k++) tick(1);
		w = (got.size() != 0) ? got.pop_front() : 20'hx;
		`CHK(w, e)
	endtask : expect_word
	task automatic test_done();
		if (error_cnt == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done

	// ****
	// scenarios
	// ****
	initial begin
		logic [3:0] c;
		logic [1:0] r;
		logic [13:0] d;
		logic [13:0] dw[8];
		logic [5:0] mc[7];
		mc = '{6'd5, 6'd15, 6'd36, 6'd37, 6'd63, 6'd40, 6'd7};
		ad_hi = 1'($random(seed));
		ad_lo = 1'($random(seed));
		tick(2);
		rst_n = 1'b1;
		`CHK({ccode, cword, mcode, hiz, busy_n}, {14'h0, CONTROL_RESET, MON_HIZ, 2'b11})
		c = 4'($random(seed));
		r = {1'b1, 1'($random(seed))};
		d = 14'($random(seed));
		m.start();
		send(adr(1'b0));
		`CHK(ack, 1'b1)
		upd({4'h0, c}, r, d);
		upd(8'h0e, 2'h1, 14'h3fff);
		`CHK(ack, 1'b1)
		upd(8'h01, 2'h2, 14'h0);
		`CHK(ack, 1'b0)
		m.stop();
		rdy = 1'b1;
		// narrow part: the top pointer bit reads as zero
		expect_word({1'b0, c[2:0], r, d});
		expect_word({4'h6, 2'h1, 14'h3fff});
		m.start();
		send(adr(1'b1));
		`CHK(ack, 1'b0)
		m.stop();
		m.start();
		send(adr(1'b0) ^ 8'h80);
		`CHK(ack, 1'b0)
		m.stop();
		m.start();
		send(adr(1'b0));
		send(PTR_BURST);
		for (int i = 0; i < 8; i++) begin
			dw[i] = 14'($random(seed));
			send({2'h3, dw[i][13:8]});
			send(dw[i][7:0]);
		end
		upd(8'h03, 2'h3, 14'h1234);
		m.stop();
		for (int i = 0; i < 8; i++) expect_word({4'(i), 2'h3, dw[i]});
		expect_word({4'h3, 2'h3, 14'h1234});
		tgl = 1'b1;
		m.start();
		send(adr(1'b0));
		send(PTR_BURST);
		send(8'hc0);
		send(8'h05);
		`CHK(burst, 1'b1)
		m.stop();
		tick(8);
		`CHK({burst, 4'(got.size())}, 5'h0)
		tgl = 1'b0;
		frame({4'h0, CMD_CLEAR_CODE}, 2'h0, d);
		`CHK(ccode, d)
		for (int v = 0; v < 2; v++) begin
			n_clr = 0;
			n_busy = 0;
			frame({4'h0, CMD_SOFT_CLEAR}, 2'h0, 14'h0);
			// a low clock enable freezes the busy count, so busy stretches by as many cycles
			clk_en = 1'b0;
			tick(50);
			clk_en = 1'b1;
			tick(900);
			`CHK({n_clr, n_busy}, {32'd1, (v ? SOFT_CLR_CYC_WIDE : SOFT_CLR_CYC_NARROW) + 32'd50})
			narrow = 1'b0;
		end
		n_busy = 0;
		frame({4'h0, CMD_NOP}, 2'h0, 14'h2aaa);
		`CHK({n_busy, ccode}, {32'd1, d})
		hw_pd = 1'b1;
		tick(5);
		`CHK(pd, 1'b1)
		hw_pd = 1'b0;
		// upper command codes must still decode on the narrow part
		narrow = 1'b1;
		frame({4'h0, CMD_POWER_DOWN}, 2'h0, 14'h0);
		`CHK({sw_pd, pd, ccode}, {2'b11, d})
		n_pd = 0;
		frame({4'h0, CMD_POWER_UP}, 2'h0, 14'h0);
		tick(400);
		`CHK({sw_pd, n_pd}, {1'b0, POWER_UP_CYC})
		d = 14'($random(seed));
		frame({4'h0, CMD_CONTROL}, 2'h0, d);
		n_rd = 0;
		frame({4'h1, CMD_CONTROL}, 2'h0, 14'h0);
		`CHK({n_rd, cword}, {32'd1, d})
		foreach (mc[i]) begin
			w12 = 1'(i);
			frame({4'h0, CMD_MONITOR}, 2'h0, w12 ? {2'h0, mc[i], 6'h0} : {mc[i], 8'h0});
			`CHK({mcode, chsel, ext1, ext2, hiz}, {mc[i], mon_exp(mc[i], narrow)})
		end
		n_rst = 0;
		n_busy = 0;
		frame({4'h0, CMD_SOFT_RESET}, 2'h0, 14'h0);
		tick(40);
		`CHK({n_rst, n_busy, ccode, cword, mcode}, {32'd1, 32'd20, 14'h0, CONTROL_RESET, MON_RESET})
		n_clr = 0;
		n_busy = 0;
		clr_n = 1'b0;
		tick(10);
		clr_n = 1'b1;
		tick(5);
		`CHK({n_clr, n_busy}, {32'd1, 32'd0})
		test_done();
	end
endmodule : tb

`default_nettype wire
